/* core/tfs_fetch_sched.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tfs_regs.svh"

// What this block does
// - each thread slot has its own instruction buffer, decoupling fetch from execution
// - with several slots in flight, each buffer keeps a skid area free
// - issued instructions stay buffered until commit, so a flush replays them
// - conditional branch direction comes from a 512-entry direction table
// - a four-entry return address stack holds recent call return addresses
// - link-type calls push their link address onto the return stack
// - jump-to-register pops the stack top as the predicted target
// - each cycle with EXEC_READY_IN high, the dispatcher issues from the ready slot of highest priority
// - ties among eligible slots are broken in round-robin rotation
// - a policy manager gives every slot a priority value
// - the policy is chosen at design time: round-robin, fixed priority or weighted round-robin
// - the reference policy is weighted round-robin by per-slot weights
// - nine slots, split at run time across at most two virtual processors
// - each slot keeps its own program counter; all share one execution unit
module tfs_fetch_sched #(
  parameter tfs_pkg::tfs_policy_e POLICY = tfs_pkg::TFS_POL_WRR
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        FETCH_VALID_IN,
  output var  logic        FETCH_READY_OUT,
  input  wire logic [3:0]  FETCH_SLOT_IN,
  input  wire logic [31:0] FETCH_PC_IN,
  input  wire logic [31:0] FETCH_INSTR_IN,
  output var  logic        PRED_VALID_OUT,
  output var  logic [3:0]  PRED_SLOT_OUT,
  output var  logic        PRED_TAKEN_OUT,
  output var  logic [31:0] PRED_TARGET_OUT,
  input  wire logic        BR_UPD_VALID_IN,
  input  wire logic [31:0] BR_UPD_PC_IN,
  input  wire logic        BR_UPD_TAKEN_IN,
  input  wire logic [8:0]  SLOT_ACTIVE_IN,
  input  wire logic [8:0]  SLOT_VP_IN,
  input  wire logic [17:0] SLOT_PRIO_IN,
  input  wire logic [35:0] SLOT_WEIGHT_IN,
  input  wire logic        EXEC_READY_IN,
  output var  logic        ISSUE_VALID_OUT,
  output var  logic [3:0]  ISSUE_SLOT_OUT,
  output var  logic        ISSUE_VP_OUT,
  output var  logic [31:0] ISSUE_PC_OUT,
  output var  logic [31:0] ISSUE_INSTR_OUT,
  output var  logic [31:0] ISSUE_NEXT_PC_OUT,
  input  wire logic        COMMIT_VALID_IN,
  input  wire logic [3:0]  COMMIT_SLOT_IN,
  input  wire logic        FLUSH_VALID_IN,
  input  wire logic [3:0]  FLUSH_SLOT_IN
);
  localparam int NS = `TFS_SLOTS;
  localparam int ND = `TFS_IBUF_DEPTH;
  localparam int NR = `TFS_RAS_DEPTH;

  // circular rotation pick: best priority wins, ties go to first after last
  function automatic tfs_pkg::tfs_slot_t pick_slot(input logic [8:0] rdy,
                                                  input logic [17:0] pr,
                                                  input tfs_pkg::tfs_slot_t last);
    int                 i;
    logic [1:0]         bp;
    logic               found;
    tfs_pkg::tfs_slot_t best;
    bp    = 2'h0;
    found = 1'b0;
    best  = last;
    for (int k = 0; k < NS; k++) begin
      i = (int'(last) + 1 + k) % NS;
      if (rdy[i] && (!found || pr[2*i +: 2] > bp)) begin
        best  = 4'(i);
        bp    = pr[2*i +: 2];
        found = 1'b1;
      end
    end
    return best;
  endfunction

  // sign-extended branch displacement added to the delay-slot address
  function automatic logic [31:0] br_target(input logic [31:0] pc, input logic [31:0] ins);
    return pc + `TFS_NEXT_OFFSET + {{14{ins[15]}}, ins[15:0], 2'h0};
  endfunction

  // reset release through two flip-flops
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // input FIFO between the fetch path and the slot buffers
  tfs_pkg::tfs_fetch_s fin;
  tfs_pkg::tfs_fetch_s fq;
  logic                fq_valid;
  logic                fq_ready;
  assign fin = '{slot: FETCH_SLOT_IN, pc: FETCH_PC_IN, instr: FETCH_INSTR_IN};

  tfs_fifo #(
    .WIDTH ($bits(tfs_pkg::tfs_fetch_s)),
    .DEPTH (`TFS_FIFO_DEPTH)
  ) u_fifo (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (rst_n),
    .s_valid_in  (FETCH_VALID_IN),
    .s_ready_out (FETCH_READY_OUT),
    .s_data_in   (fin),
    .m_valid_out (fq_valid),
    .m_ready_in  (fq_ready),
    .m_data_out  (fq)
  );

  // per-slot buffers: tail writes, issue reads, retire frees
  tfs_pkg::tfs_entry_s ibuf_q [NS][ND];
  logic [3:0]          tail_q [NS];
  logic [3:0]          iss_q  [NS];
  logic [3:0]          ret_q  [NS];
  logic [31:0]         slot_pc_q [NS];
  logic [3:0]          credit_q  [NS];
  logic [8:0]          inflight;
  logic [8:0]          room;
  logic [8:0]          ready;
  logic [8:0]          has_credit;
  logic [17:0]         prio;
  logic                multi;
  int                  n_inflight;

  // skid area is held back only while more than one slot is in flight
  always_comb begin
    n_inflight = 0;
    for (int s = 0; s < NS; s++) begin
      inflight[s] = tail_q[s] != ret_q[s];
      n_inflight  = n_inflight + int'(inflight[s]);
    end
  end
  assign multi = n_inflight > 1;

  // room, readiness and policy priority per slot
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      room[s]       = (tail_q[s] - ret_q[s]) < (multi ? 4'(ND - `TFS_IBUF_SKID) : 4'(ND));
      ready[s]      = SLOT_ACTIVE_IN[s] && (tail_q[s] != iss_q[s]) &&
                      !(FLUSH_VALID_IN && FLUSH_SLOT_IN == 4'(s));
      has_credit[s] = credit_q[s] != 4'h0;
      case (POLICY)
        tfs_pkg::TFS_POL_RR:    prio[2*s +: 2] = 2'h0;
        tfs_pkg::TFS_POL_FIXED: prio[2*s +: 2] = SLOT_PRIO_IN[2*s +: 2];
        tfs_pkg::TFS_POL_WRR:   prio[2*s +: 2] = {1'b0, has_credit[s]};
        default:                prio[2*s +: 2] = 2'h0;
      endcase
    end
  end

  // dispatcher selection
  tfs_pkg::tfs_slot_t  last_q;
  tfs_pkg::tfs_slot_t  sel;
  tfs_pkg::tfs_entry_s sel_ent;
  wire                 do_issue = EXEC_READY_IN && (ready != 9'h000);
  wire                 reload   = (ready & has_credit) == 9'h000;
  assign sel     = pick_slot(ready, prio, last_q);
  assign sel_ent = ibuf_q[sel][iss_q[sel][2:0]];

  // fetch decode on the instruction leaving the FIFO
  wire [5:0]  op      = fq.instr[`TFS_OP_MSB:`TFS_OP_LSB];
  wire [5:0]  fn      = fq.instr[5:0];
  wire [4:0]  rt      = fq.instr[20:16];
  wire        is_jal  = op == `TFS_OP_JAL;
  wire        is_jump_and_link_register = op == `TFS_OP_SPECIAL && fn == `TFS_FN_JUMP_AND_LINK_REGISTER;
  wire        is_jr   = op == `TFS_OP_SPECIAL && fn == `TFS_FN_JR;
  wire        is_bal  = op == `TFS_OP_REGIMM && rt == `TFS_RT_BRANCH_NONNEG_AND_LINK;
  wire        is_cond = (op >= `TFS_OP_BEQ && op <= `TFS_OP_BGTZ) ||
                        (op == `TFS_OP_REGIMM && (rt == `TFS_RT_BLTZ || rt == `TFS_RT_BGEZ));
  wire        take_in = fq_valid && fq_ready;
  wire        push    = take_in && (is_jal || is_jump_and_link_register || is_bal);
  wire        pop     = take_in && is_jr;
  wire [31:0] link    = fq.pc + `TFS_LINK_OFFSET;
  wire [31:0] jtgt    = {link[31:28], fq.instr[25:0], 2'h0};

  assign fq_ready = room[fq.slot];

  // direction table, return stack and lookup
  logic [1:0]  bdt_q [`TFS_BDT_ENTRIES];
  logic [31:0] ras_q [NR];
  logic [2:0]  ras_cnt_q;
  wire  [8:0]  rd_idx = fq.pc[10:2];
  wire  [8:0]  up_idx = BR_UPD_PC_IN[10:2];
  wire  [1:0]  up_ctr = bdt_q[up_idx];
  wire         cond_taken = bdt_q[rd_idx][1];
  wire         ras_hit    = ras_cnt_q != 3'h0;

  // direction counters train from resolved branches
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      for (int e = 0; e < `TFS_BDT_ENTRIES; e++) begin
        bdt_q[e] <= `TFS_BDT_RESET;
      end
    end else if (BR_UPD_VALID_IN) begin
      if (BR_UPD_TAKEN_IN && up_ctr != 2'h3) begin
        bdt_q[up_idx] <= up_ctr + 2'h1;
      end else if (!BR_UPD_TAKEN_IN && up_ctr != 2'h0) begin
        bdt_q[up_idx] <= up_ctr - 2'h1;
      end
    end
  end

  // return stack: entry 0 is the top, shifting drops the oldest
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ras_cnt_q <= 3'h0;
      for (int r = 0; r < NR; r++) begin
        ras_q[r] <= 32'h00000000;
      end
    end else if (push) begin
      ras_q[0] <= link;
      for (int r = 1; r < NR; r++) begin
        ras_q[r] <= ras_q[r-1];
      end
      if (ras_cnt_q != 3'(NR)) begin
        ras_cnt_q <= ras_cnt_q + 3'h1;
      end
    end else if (pop && ras_hit) begin
      for (int r = 0; r < NR - 1; r++) begin
        ras_q[r] <= ras_q[r+1];
      end
      ras_q[NR-1] <= 32'h00000000;
      ras_cnt_q   <= ras_cnt_q - 3'h1;
    end
  end

  // prediction outputs for each JAL, branch-and-link, conditional branch and stack-hit JR taken into a buffer
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PRED_VALID_OUT  <= 1'b0;
      PRED_SLOT_OUT   <= 4'h0;
      PRED_TAKEN_OUT  <= 1'b0;
      PRED_TARGET_OUT <= 32'h00000000;
    end else begin
      PRED_VALID_OUT <= take_in && (is_jal || is_bal || is_cond || (is_jr && ras_hit));
      PRED_SLOT_OUT  <= fq.slot;
      if (is_jal) begin
        PRED_TAKEN_OUT  <= 1'b1;
        PRED_TARGET_OUT <= jtgt;
      end else if (is_jr) begin
        PRED_TAKEN_OUT  <= ras_hit;
        PRED_TARGET_OUT <= ras_q[0];
      end else if (is_bal || is_cond) begin
        PRED_TAKEN_OUT  <= cond_taken;
        PRED_TARGET_OUT <= br_target(fq.pc, fq.instr);
      end else begin
        PRED_TAKEN_OUT  <= 1'b0;
        PRED_TARGET_OUT <= link - `TFS_NEXT_OFFSET;
      end
    end
  end

  // buffer storage written at the tail of the fetched slot
  always_ff @(posedge SYS_CLK_IN) begin
    if (take_in) begin
      ibuf_q[fq.slot][tail_q[fq.slot][2:0]] <= '{pc: fq.pc, instr: fq.instr};
    end
  end

  // per-slot pointers, program counters and credits
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 4'(NS - 1);
      for (int s = 0; s < NS; s++) begin
        tail_q[s]    <= 4'h0;
        iss_q[s]     <= 4'h0;
        ret_q[s]     <= 4'h0;
        slot_pc_q[s] <= 32'h00000000;
        credit_q[s]  <= 4'h0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (take_in && fq.slot == 4'(s)) begin
          tail_q[s] <= tail_q[s] + 4'h1;
        end
        if (COMMIT_VALID_IN && COMMIT_SLOT_IN == 4'(s) && ret_q[s] != iss_q[s]) begin
          ret_q[s] <= ret_q[s] + 4'h1;
        end
        if (FLUSH_VALID_IN && FLUSH_SLOT_IN == 4'(s)) begin
          iss_q[s]     <= ret_q[s];
          slot_pc_q[s] <= ibuf_q[s][ret_q[s][2:0]].pc;
        end else if (do_issue && sel == 4'(s)) begin
          iss_q[s]     <= iss_q[s] + 4'h1;
          slot_pc_q[s] <= sel_ent.pc + `TFS_NEXT_OFFSET;
        end
        if (reload) begin
          credit_q[s] <= SLOT_WEIGHT_IN[4*s +: 4];
        end else if (do_issue && sel == 4'(s) && has_credit[s]) begin
          credit_q[s] <= credit_q[s] - 4'h1;
        end
      end
      if (do_issue) begin
        last_q <= sel;
      end
    end
  end

  // issue port toward the shared execution unit
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ISSUE_VALID_OUT   <= 1'b0;
      ISSUE_SLOT_OUT    <= 4'h0;
      ISSUE_VP_OUT      <= 1'b0;
      ISSUE_PC_OUT      <= 32'h00000000;
      ISSUE_INSTR_OUT   <= 32'h00000000;
      ISSUE_NEXT_PC_OUT <= 32'h00000000;
    end else begin
      ISSUE_VALID_OUT   <= do_issue;
      ISSUE_SLOT_OUT    <= sel;
      ISSUE_VP_OUT      <= SLOT_VP_IN[sel];
      ISSUE_PC_OUT      <= sel_ent.pc;
      ISSUE_INSTR_OUT   <= sel_ent.instr;
      ISSUE_NEXT_PC_OUT <= sel_ent.pc + `TFS_NEXT_OFFSET;
    end
  end
endmodule

`default_nettype wire

/* shared/tfs_regs.svh */
`ifndef TFS_REGS_SVH
`define TFS_REGS_SVH

// thread slots and per-slot buffering
`define TFS_SLOTS        9
`define TFS_VPS          2
`define TFS_IBUF_DEPTH   8
`define TFS_IBUF_SKID    2
`define TFS_FIFO_DEPTH   16

// branch prediction sizes
`define TFS_BDT_ENTRIES  512
`define TFS_BDT_RESET    2'h1
`define TFS_RAS_DEPTH    4

// instruction field positions and codes
`define TFS_OP_MSB       31
`define TFS_OP_LSB       26
`define TFS_OP_SPECIAL   6'h00
`define TFS_OP_REGIMM    6'h01
`define TFS_OP_JAL       6'h03
`define TFS_OP_BEQ       6'h04
`define TFS_OP_BGTZ      6'h07
`define TFS_FN_JR        6'h08
`define TFS_FN_JUMP_AND_LINK_REGISTER      6'h09
`define TFS_RT_BLTZ      5'h00
`define TFS_RT_BGEZ      5'h01
`define TFS_RT_BRANCH_NONNEG_AND_LINK    5'h11
`define TFS_LINK_OFFSET  32'h00000008
`define TFS_NEXT_OFFSET  32'h00000004

`endif

/* shared/tfs_pkg.sv */
package tfs_pkg;

  typedef logic [3:0] tfs_slot_t;

  // one fetched instruction on its way into a slot buffer
  typedef struct packed {
    tfs_slot_t   slot;
    logic [31:0] pc;
    logic [31:0] instr;
  } tfs_fetch_s;

  // one buffered instruction as stored and issued
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] instr;
  } tfs_entry_s;

  // policy manager flavour chosen at design time
  typedef enum {
    TFS_POL_RR,
    TFS_POL_FIXED,
    TFS_POL_WRR
  } tfs_policy_e;

endpackage

/* core/tfs_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module tfs_fifo #(
  parameter int WIDTH = 68,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             s_valid_in,
  output var  logic             s_ready_out,
  input  wire logic [WIDTH-1:0] s_data_in,
  output var  logic             m_valid_out,
  input  wire logic             m_ready_in,
  output var  logic [WIDTH-1:0] m_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  wire              push = s_valid_in && s_ready_out;
  wire              pop  = m_valid_out && m_ready_in;

  // occupancy after this cycle's push and pop
  assign cnt_d      = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign m_data_out = mem_q[rd_q];

  // pointers, count and registered flags
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q        <= '0;
      rd_q        <= '0;
      cnt_q       <= '0;
      s_ready_out <= 1'b0;
      m_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q       <= cnt_d;
      s_ready_out <= cnt_d != (AW+1)'(DEPTH);
      m_valid_out <= cnt_d != '0;
    end
  end

  // storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= s_data_in;
    end
  end
endmodule

`default_nettype wire

/* sim/tfs_fetch_sched_chk.sv */
`timescale 1ns/10ps
`default_nettype none

module tfs_fetch_sched_chk (
  input wire logic        SYS_CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        FETCH_READY_OUT,
  input wire logic        PRED_VALID_OUT,
  input wire logic [3:0]  PRED_SLOT_OUT,
  input wire logic [8:0]  SLOT_ACTIVE_IN,
  input wire logic [8:0]  SLOT_VP_IN,
  input wire logic        EXEC_READY_IN,
  input wire logic        ISSUE_VALID_OUT,
  input wire logic [3:0]  ISSUE_SLOT_OUT,
  input wire logic        ISSUE_VP_OUT,
  input wire logic [31:0] ISSUE_PC_OUT,
  input wire logic [31:0] ISSUE_NEXT_PC_OUT,
  input wire logic        FLUSH_VALID_IN,
  input wire logic [3:0]  FLUSH_SLOT_IN
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // reset release, then the fetch side must open within a few cycles
  sequence rst_release;
    $rose(RESET_N_IN);
  endsequence
  sequence issued;
    ISSUE_VALID_OUT;
  endsequence

  // fetch ready, issue and prediction relations
  ready_open_a: assert property (rst_release |-> ##[1:5] FETCH_READY_OUT)
    else $error("fetch ready not raised after reset");
  exec_gate_a: assert property (issued |-> $past(EXEC_READY_IN))
    else $error("issue without execution ready");
  slot_active_a: assert property (issued |-> (($past(SLOT_ACTIVE_IN) >> ISSUE_SLOT_OUT) & 9'h001) == 9'h001)
    else $error("issue from inactive slot");
  next_pc_a: assert property (issued |-> ISSUE_NEXT_PC_OUT == ISSUE_PC_OUT + 32'h00000004)
    else $error("next pc wrong");
  vp_map_a: assert property (issued |-> (($past(SLOT_VP_IN) >> ISSUE_SLOT_OUT) & 9'h001) == {8'h00, ISSUE_VP_OUT})
    else $error("virtual processor of issue wrong");
  issue_range_a: assert property (issued |-> ISSUE_SLOT_OUT <= 4'h8)
    else $error("issue slot out of range");
  pred_range_a: assert property (PRED_VALID_OUT |-> PRED_SLOT_OUT <= 4'h8)
    else $error("prediction slot out of range");
  flush_hold_a: assert property (ISSUE_VALID_OUT && $past(FLUSH_VALID_IN) |-> ISSUE_SLOT_OUT != $past(FLUSH_SLOT_IN))
    else $error("flushed slot issued");
endmodule

`default_nettype wire

/* sim/tfs_exec_model.sv */
`timescale 1ns/10ps
`default_nettype none

module tfs_exec_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       slow_in,
  input  wire logic       commit_en_in,
  input  wire logic       issue_valid_in,
  input  wire logic [3:0] issue_slot_in,
  output var  logic       exec_ready_out,
  output var  logic       commit_valid_out,
  output var  logic [3:0] commit_slot_out
);
  logic phase_q;

  // retires each issue one cycle later; idle slot field keeps changing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q          <= 1'b0;
      commit_valid_out <= 1'b0;
      commit_slot_out  <= 4'h0;
    end else begin
      phase_q          <= ~phase_q;
      commit_valid_out <= issue_valid_in && commit_en_in;
      commit_slot_out  <= issue_valid_in ? issue_slot_in : ~commit_slot_out;
    end
  end

  // takes an issue every cycle, or every other cycle when slow
  assign exec_ready_out = rst_n_in && (!slow_in || phase_q);
endmodule

`default_nettype wire

/* sim/tfs_fetch_sched_test.sv */
`timescale 1ns/10ps
`default_nettype none

module tfs_fetch_sched_test;
  logic        clk, rst_n, f_valid, f_ready, p_valid, p_taken, u_valid, u_taken, e_ready, i_valid;
  logic        c_valid, fl_valid, slow, c_en;
  logic [3:0]  f_slot, p_slot, i_slot, c_slot, fl_slot;
  logic [8:0]  active;
  logic [31:0] f_pc, f_instr, p_target, u_pc, i_pc, i_instr;
  logic [35:0] iss_q[$];
  logic [31:0] ins_q[$];
  logic [36:0] pred_q[$];
  int          num_errors, num_checks;

  // design with fixed slot split, unused priorities and unit weights
  tfs_fetch_sched uut (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .FETCH_VALID_IN(f_valid), .FETCH_READY_OUT(f_ready),
    .FETCH_SLOT_IN(f_slot), .FETCH_PC_IN(f_pc), .FETCH_INSTR_IN(f_instr), .PRED_VALID_OUT(p_valid),
    .PRED_SLOT_OUT(p_slot), .PRED_TAKEN_OUT(p_taken), .PRED_TARGET_OUT(p_target), .BR_UPD_VALID_IN(u_valid),
    .BR_UPD_PC_IN(u_pc), .BR_UPD_TAKEN_IN(u_taken), .SLOT_ACTIVE_IN(active), .SLOT_VP_IN(9'h0F0),
    .SLOT_PRIO_IN(18'h00000), .SLOT_WEIGHT_IN({9{4'h1}}), .EXEC_READY_IN(e_ready), .ISSUE_VALID_OUT(i_valid),
    .ISSUE_SLOT_OUT(i_slot), .ISSUE_VP_OUT(), .ISSUE_PC_OUT(i_pc), .ISSUE_INSTR_OUT(i_instr), .ISSUE_NEXT_PC_OUT(),
    .COMMIT_VALID_IN(c_valid), .COMMIT_SLOT_IN(c_slot), .FLUSH_VALID_IN(fl_valid), .FLUSH_SLOT_IN(fl_slot));

  // execution side partner
  tfs_exec_model exec (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .commit_en_in(c_en),
    .issue_valid_in(i_valid), .issue_slot_in(i_slot), .exec_ready_out(e_ready), .commit_valid_out(c_valid),
    .commit_slot_out(c_slot));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // record issues and predictions
  always @(posedge clk) begin
    if (i_valid === 1'b1) iss_q.push_back({i_slot, i_pc});
    if (i_valid === 1'b1) ins_q.push_back(i_instr);
    if (p_valid === 1'b1) pred_q.push_back({p_slot, p_taken, p_target});
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic wait_issues(input int n);
    for (int k = 0; k < 400 && iss_q.size() < n; k++) @(posedge clk);
    if (iss_q.size() < n) num_errors++;
  endtask

  // offer one word and hold it until taken
  task automatic fetch(input logic [3:0] s, input logic [31:0] pc, input logic [31:0] ins);
    f_valid <= 1'b1;
    f_slot <= s;
    f_pc <= pc;
    f_instr <= ins;
    @(posedge clk);
    for (int k = 0; k < 400 && f_ready !== 1'b1; k++) @(posedge clk);
    if (f_ready !== 1'b1) num_errors++;
  endtask

  task automatic test_return_stack();
    logic [31:0] w[5] = '{32'h0C000040, 32'h0080F809, 32'h04110010, 32'h0C000040, 32'h0C000040};
    logic [36:0] e[8] = '{37'h0500000100, 37'h0400001064, 37'h0500000100, 37'h0500000100,
                          37'h0500001048, 37'h0500001038, 37'h0500001028, 37'h0500001018};
    iss_q.delete();
    pred_q.delete();
    active <= 9'h004;
    for (int i = 0; i < 10; i++) fetch(4'h2, 32'h00001000 + 32'(i * 16), i < 5 ? w[i] : 32'h03E00008);
    f_valid <= 1'b0;
    wait_issues(10);
    for (int i = 0; i < 10; i++) check(iss_q[i], {4'h2, 32'h00001000 + 32'(i * 16)});
    for (int i = 0; i < 8; i++) check(pred_q[i], e[i]);
    check(pred_q.size(), 8);
    $display("return stack test done");
  endtask

  task automatic test_direction();
    iss_q.delete();
    pred_q.delete();
    active <= 9'h002;
    fetch(4'h1, 32'h00002000, 32'h10220003);
    f_valid <= 1'b0;
    wait_issues(1);
    u_valid <= 1'b1;
    u_pc <= 32'h00002000;
    u_taken <= 1'b1;
    repeat (2) @(posedge clk);
    u_valid <= 1'b0;
    fetch(4'h1, 32'h00002000, 32'h10220003);
    f_valid <= 1'b0;
    wait_issues(2);
    check(pred_q[0], 37'h0200002010);
    check(pred_q[1], 37'h0300002010);
    $display("direction test done");
  endtask

  task automatic test_replay();
    iss_q.delete();
    ins_q.delete();
    c_en <= 1'b0;
    active <= 9'h001;
    fetch(4'h0, 32'h00000100, 32'h24000001);
    fetch(4'h0, 32'h00000104, 32'h24000002);
    f_valid <= 1'b0;
    wait_issues(2);
    fl_valid <= 1'b1;
    fl_slot <= 4'h0;
    c_en <= 1'b1;
    @(posedge clk);
    fl_valid <= 1'b0;
    wait_issues(4);
    for (int i = 0; i < 4; i++) check(iss_q[i], {4'h0, 32'h00000100 + 32'((i % 2) * 4)});
    for (int i = 0; i < 4; i++) check(ins_q[i], 32'h24000001 + 32'(i % 2));
    $display("replay test done");
  endtask

  task automatic test_rotation();
    iss_q.delete();
    active <= 9'h000;
    for (int i = 6; i > 3; i--) fetch(4'(i), 32'h00004000 + 32'(i * 4), 32'h24000004);
    f_valid <= 1'b0;
    repeat (6) @(posedge clk);
    active <= 9'h070;
    fl_valid <= 1'b1;
    fl_slot <= 4'h4;
    @(posedge clk);
    fl_valid <= 1'b0;
    wait_issues(3);
    // flushed slot 4 sits out the first pick, so the rotation runs 5, 6, 4
    for (int i = 0; i < 3; i++) begin
      check(iss_q[i], {4'((i + 1) % 3 + 4), 32'h00004000 + 32'(((i + 1) % 3 + 4) * 4)});
    end
    $display("rotation test done");
  endtask

  task automatic test_fill_drain();
    int n = 0;
    iss_q.delete();
    active <= 9'h000;
    f_valid <= 1'b1;
    f_slot <= 4'h3;
    f_instr <= 32'h24000003;
    f_pc <= 32'h00003000;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (f_ready === 1'b1) begin
        n++;
        f_pc <= 32'h00003000 + 32'(n * 4);
      end
    end
    f_valid <= 1'b0;
    check(n, 24);
    check(f_ready, 1'b0);
    slow <= 1'b1;
    active <= 9'h008;
    wait_issues(24);
    for (int i = 0; i < 24; i++) check(iss_q[i], {4'h3, 32'h00003000 + 32'(i * 4)});
    check(f_ready, 1'b1);
    $display("fill and drain test done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    {rst_n, f_valid, u_valid, u_taken, fl_valid, slow} = '0;
    {f_slot, fl_slot, active} = '0;
    {f_pc, f_instr, u_pc} = '0;
    c_en = 1'b1;
    repeat (4) @(posedge clk);
    check(f_ready, 1'b0);
    rst_n <= 1'b1;
    for (int k = 0; k < 10 && f_ready !== 1'b1; k++) @(posedge clk);
    check(f_ready, 1'b1);
    test_return_stack();
    test_direction();
    test_replay();
    test_rotation();
    test_fill_drain();
    report_and_stop();
  end

  // watchdog
  initial begin
    #50us;
    num_errors++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end
endmodule

bind tfs_fetch_sched tfs_fetch_sched_chk chk (.SYS_CLK_IN, .RESET_N_IN, .FETCH_READY_OUT, .PRED_VALID_OUT,
  .PRED_SLOT_OUT, .SLOT_ACTIVE_IN, .SLOT_VP_IN, .EXEC_READY_IN, .ISSUE_VALID_OUT, .ISSUE_SLOT_OUT,
  .ISSUE_VP_OUT, .ISSUE_PC_OUT, .ISSUE_NEXT_PC_OUT, .FLUSH_VALID_IN, .FLUSH_SLOT_IN);

`default_nettype wire
